// *** miet_regs.vh ***
// register map, field layout, opcodes and reset values of the execute tail
`ifndef MIET_REGS_VH
`define MIET_REGS_VH

// apb byte offsets, one aligned word each
`define MIET_OFS_CMD 8'h00
`define MIET_OFS_STAT 8'h04
`define MIET_OFS_ACC 8'h08
`define MIET_OFS_FLAG 8'h0C
`define MIET_OFS_TPLO 8'h10
`define MIET_OFS_TPHI 8'h14
`define MIET_OFS_THL 8'h18
`define MIET_OFS_DPTR 8'h1C
`define MIET_OFS_DDAT 8'h20
`define MIET_OFS_PPTR 8'h24
`define MIET_OFS_PDAT 8'h28

// command word fields
`define MIET_CMD_OP_LSB 0
`define MIET_CMD_OP_MSB 4
`define MIET_CMD_BIT_LSB 5
`define MIET_CMD_BIT_MSB 7
`define MIET_CMD_ADR_LSB 8
`define MIET_CMD_ADR_MSB 15
`define MIET_CMD_SEC_LSB 16
`define MIET_CMD_IMM_LSB 24
`define MIET_CMD_IMM_MSB 31

// status word bits
`define MIET_ST_BUSY 0
`define MIET_ST_SKIP 1
`define MIET_ST_BAD 2

// flag word bits
`define MIET_FL_C 0
`define MIET_FL_HCARRY 1
`define MIET_FL_Z 2
`define MIET_FL_SEXCESS 3
`define MIET_FL_SCARRY 4

// opcodes of the command word
`define MIET_OP_NIB_XCHG 5'h00
`define MIET_OP_SKIP_NULL 5'h01
`define MIET_OP_SKIP_NULL_MOV 5'h02
`define MIET_OP_SKIP_NULL_BIT 5'h03
`define MIET_OP_TRD_PAGED 5'h04
`define MIET_OP_TRD_FINAL 5'h05
`define MIET_OP_PTRD_PAGED 5'h06
`define MIET_OP_PTRD_FINAL 5'h07
`define MIET_OP_XOR_ACC 5'h08
`define MIET_OP_XOR_MEM 5'h09
`define MIET_OP_XOR_IMM 5'h0A
`define MIET_OP_FADC 5'h0B
`define MIET_OP_FADC_MEM 5'h0C
`define MIET_OP_FADD 5'h0D
`define MIET_OP_FADD_MEM 5'h0E
`define MIET_OP_FAND 5'h0F
`define MIET_OP_FAND_MEM 5'h10
`define MIET_OP_FZERO 5'h11
`define MIET_OP_FZERO_BIT 5'h12
`define MIET_OP_FINV 5'h13
`define MIET_OP_FINV_ACC 5'h14
`define MIET_OP_FDAA 5'h15
`define MIET_OP_FDEC 5'h16
`define MIET_OP_FDEC_ACC 5'h17
`define MIET_OP_FINC 5'h18
`define MIET_OP_FINC_ACC 5'h19
`define MIET_OP_FMOV_TO_ACC 5'h1A
`define MIET_OP_FMOV_TO_MEM 5'h1B
`define MIET_OP_FOR 5'h1C

// constants of the datapath
`define MIET_BYTE_ZERO 8'h00
`define MIET_BYTE_ONE 8'h01
`define MIET_NIB_NINE 4'h9
`define MIET_ADJ_LO 8'h06
`define MIET_ADJ_HI 8'h60
`define MIET_RST_BYTE 8'h00
`define MIET_RST_WORD 32'h00000000

`endif

// *** miet_core.v ***
// execute tail of an 8-bit core: nibble swap, zero skips, table reads, xor, far ops
`timescale 1ns/1ps
`include "miet_regs.vh"

// How it works
// - nibble exchange loads acc with swapped nibbles of memory byte, memory and flags kept
// - skip-when-null skips next instruction when byte is zero, no flags
// - skip-when-null-with-move copies byte to acc and skips when byte is zero
// - bit form skips when selected bit is zero, no flags changed
// - a taken skip adds one dummy cycle, making the instruction two cycles
// - paged table read uses pointer high and low; low byte to memory, high to latch
// - final-page table read uses last page plus pointer low only
// - preincrement table reads bump pointer low first then read with new value
// - xor of acc with byte or immediate into acc or memory, only zero flag
// - far forms reach every data memory section; normal forms only section zero
// - far add with carry sums acc, byte and carry; updates all five add flags
// - far add sums acc and byte; updates all five add flags
// - far and into acc or memory, only zero flag affected
// - far zero fill clears byte or one bit, no flags
// - far invert complements byte in place or into acc, zero flag updated
// - decimal adjust adds 6 per nibble above 9 or on carry, result to memory
// - decimal adjust alters only carry, set when acc high nibble is above 9 or carry was set
// - far decrement in place or into acc, zero flag updated
// - far increment in place or into acc, zero flag updated
// - far move copies byte to acc or acc to byte, no flags
// - far or into acc, only zero flag affected
module miet_core #(
  parameter SEC_W = 2,
  parameter PM_AW = 10
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg busy_r,
  output reg skip_slot_r
);

  localparam DM_AW = 8 + SEC_W;
  localparam DM_DEPTH = 1 << DM_AW;
  localparam PM_DEPTH = 1 << PM_AW;

  // state codes of the execute sequencer
  localparam ST_IDLE = 2'b00;
  localparam ST_EXEC = 2'b01;
  localparam ST_DUMMY = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // storage

  reg [7:0] dmem [0:DM_DEPTH-1];
  reg [15:0] pmem [0:PM_DEPTH-1];

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [31:0] cmd_r;
  reg [7:0] acc_r;
  reg c_r;
  reg hcarry_r;
  reg z_r;
  reg sexcess_r;
  reg scarry_r;
  reg [7:0] tplo_r;
  reg [7:0] tphi_r;
  reg [7:0] thl_r;
  reg [DM_AW-1:0] dptr_r;
  reg [PM_AW-1:0] pptr_r;
  reg skipped_r;
  reg bad_r;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup = psel & ~penable;
  wire done = psel & penable & pready;
  wire wr = done & pwrite & ~pslverr;
  wire hit;
  reg [31:0] rd_mux;

  // only the eleven aligned words answer; the rest return an error
  assign hit = (paddr[1:0] == 2'b00) && (paddr <= `MIET_OFS_PDAT);

  // read mux, captured in the setup cycle so prdata is a flop
  always @* begin
    rd_mux = `MIET_RST_WORD;
    case (paddr)
      `MIET_OFS_CMD: rd_mux = cmd_r;
      `MIET_OFS_STAT: rd_mux = {29'h0000000, bad_r, skipped_r, busy_r};
      `MIET_OFS_ACC: rd_mux = {24'h000000, acc_r};
      `MIET_OFS_FLAG: rd_mux = {27'h0000000, scarry_r, sexcess_r, z_r, hcarry_r, c_r};
      `MIET_OFS_TPLO: rd_mux = {24'h000000, tplo_r};
      `MIET_OFS_TPHI: rd_mux = {24'h000000, tphi_r};
      `MIET_OFS_THL: rd_mux = {24'h000000, thl_r};
      `MIET_OFS_DPTR: rd_mux = {{(32-DM_AW){1'b0}}, dptr_r};
      `MIET_OFS_DDAT: rd_mux = {24'h000000, dmem[dptr_r]};
      `MIET_OFS_PPTR: rd_mux = {{(32-PM_AW){1'b0}}, pptr_r};
      `MIET_OFS_PDAT: rd_mux = {16'h0000, pmem[pptr_r]};
      default: rd_mux = `MIET_RST_WORD;
    endcase
  end

  // one access cycle with no wait: pready rises in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `MIET_RST_WORD;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup && !pwrite && hit) begin
        prdata <= rd_mux;
      end else if (done) begin
        prdata <= `MIET_RST_WORD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch

  wire [4:0] op = cmd_r[`MIET_CMD_OP_MSB:`MIET_CMD_OP_LSB];
  wire [2:0] bsel = cmd_r[`MIET_CMD_BIT_MSB:`MIET_CMD_BIT_LSB];
  wire [7:0] imm = cmd_r[`MIET_CMD_IMM_MSB:`MIET_CMD_IMM_LSB];
  wire [SEC_W-1:0] sec = cmd_r[`MIET_CMD_SEC_LSB+SEC_W-1:`MIET_CMD_SEC_LSB];
  wire far_op = (op >= `MIET_OP_FADC);
  // normal forms are pinned to section zero, far forms take any section
  wire [DM_AW-1:0] ea = {(far_op ? sec : {SEC_W{1'b0}}),
                         cmd_r[`MIET_CMD_ADR_MSB:`MIET_CMD_ADR_LSB]};
  wire [7:0] opd = dmem[ea];

  // preincrement variants read with the bumped low pointer
  wire pre_inc = (op == `MIET_OP_PTRD_PAGED) || (op == `MIET_OP_PTRD_FINAL);
  wire [7:0] tplo_use = pre_inc ? tplo_r + `MIET_BYTE_ONE : tplo_r;
  wire final_pg = (op == `MIET_OP_TRD_FINAL) || (op == `MIET_OP_PTRD_FINAL);
  wire [15:0] tp_full = {tphi_r, tplo_use};
  // the final page is the all-ones page above the low pointer
  wire [PM_AW-1:0] pm_ea = final_pg ? {{(PM_AW-8){1'b1}}, tplo_use}
                                    : tp_full[PM_AW-1:0];
  wire [15:0] pword = pmem[pm_ea];

  // adder shared by both far add forms
  wire cin = (op == `MIET_OP_FADC) || (op == `MIET_OP_FADC_MEM) ? c_r : 1'b0;
  wire [8:0] sum9 = {1'b0, acc_r} + {1'b0, opd} + {8'h00, cin};
  wire [4:0] sum5 = {1'b0, acc_r[3:0]} + {1'b0, opd[3:0]} + {4'h0, cin};
  wire add_excess = (acc_r[7] == opd[7]) && (sum9[7] != acc_r[7]);

  // decimal adjust terms
  wire da_lo = (acc_r[3:0] > `MIET_NIB_NINE) || hcarry_r;
  wire da_hi = (acc_r[7:4] > `MIET_NIB_NINE) || c_r;
  wire [7:0] da_add = (da_lo ? `MIET_ADJ_LO : `MIET_BYTE_ZERO)
                    | (da_hi ? `MIET_ADJ_HI : `MIET_BYTE_ZERO);
  wire [8:0] da9 = {1'b0, acc_r} + {1'b0, da_add};

  ////////////////////////////////////////////////////////////////////////////
  // execute decode

  reg acc_we;
  reg [7:0] acc_v;
  reg mem_we;
  reg [7:0] mem_v;
  reg thl_we;
  reg z_we;
  reg [7:0] z_src;
  reg ar_we;
  reg c_we;
  reg c_v;
  reg skip;
  reg bad;

  // one result path per opcode; flag writes follow each form
  always @* begin
    acc_we = 1'b0;
    acc_v = acc_r;
    mem_we = 1'b0;
    mem_v = opd;
    thl_we = 1'b0;
    z_we = 1'b0;
    z_src = `MIET_BYTE_ZERO;
    ar_we = 1'b0;
    c_we = 1'b0;
    c_v = c_r;
    skip = 1'b0;
    bad = 1'b0;
    case (op)
      `MIET_OP_NIB_XCHG: begin
        acc_we = 1'b1;
        acc_v = {opd[3:0], opd[7:4]};
      end
      `MIET_OP_SKIP_NULL: skip = (opd == `MIET_BYTE_ZERO);
      `MIET_OP_SKIP_NULL_MOV: begin
        acc_we = 1'b1;
        acc_v = opd;
        skip = (opd == `MIET_BYTE_ZERO);
      end
      `MIET_OP_SKIP_NULL_BIT: skip = ~opd[bsel];
      `MIET_OP_TRD_PAGED, `MIET_OP_TRD_FINAL,
      `MIET_OP_PTRD_PAGED, `MIET_OP_PTRD_FINAL: begin
        mem_we = 1'b1;
        mem_v = pword[7:0];
        thl_we = 1'b1;
      end
      `MIET_OP_XOR_ACC, `MIET_OP_XOR_IMM: begin
        acc_we = 1'b1;
        acc_v = acc_r ^ ((op == `MIET_OP_XOR_IMM) ? imm : opd);
        z_we = 1'b1;
        z_src = acc_v;
      end
      `MIET_OP_XOR_MEM: begin
        mem_we = 1'b1;
        mem_v = acc_r ^ opd;
        z_we = 1'b1;
        z_src = mem_v;
      end
      `MIET_OP_FADC, `MIET_OP_FADD: begin
        acc_we = 1'b1;
        acc_v = sum9[7:0];
        ar_we = 1'b1;
        z_we = 1'b1;
        z_src = sum9[7:0];
      end
      `MIET_OP_FADC_MEM, `MIET_OP_FADD_MEM: begin
        mem_we = 1'b1;
        mem_v = sum9[7:0];
        ar_we = 1'b1;
        z_we = 1'b1;
        z_src = sum9[7:0];
      end
      `MIET_OP_FAND: begin
        acc_we = 1'b1;
        acc_v = acc_r & opd;
        z_we = 1'b1;
        z_src = acc_v;
      end
      `MIET_OP_FAND_MEM: begin
        mem_we = 1'b1;
        mem_v = acc_r & opd;
        z_we = 1'b1;
        z_src = mem_v;
      end
      `MIET_OP_FZERO: begin
        mem_we = 1'b1;
        mem_v = `MIET_BYTE_ZERO;
      end
      `MIET_OP_FZERO_BIT: begin
        mem_we = 1'b1;
        mem_v = opd & ~(`MIET_BYTE_ONE << bsel);
      end
      `MIET_OP_FINV: begin
        mem_we = 1'b1;
        mem_v = ~opd;
        z_we = 1'b1;
        z_src = mem_v;
      end
      `MIET_OP_FINV_ACC: begin
        acc_we = 1'b1;
        acc_v = ~opd;
        z_we = 1'b1;
        z_src = acc_v;
      end
      `MIET_OP_FDAA: begin
        mem_we = 1'b1;
        mem_v = da9[7:0];
        c_we = 1'b1;
        c_v = da_hi | da9[8];
      end
      `MIET_OP_FDEC, `MIET_OP_FDEC_ACC: begin
        acc_we = (op == `MIET_OP_FDEC_ACC);
        mem_we = (op == `MIET_OP_FDEC);
        acc_v = opd - `MIET_BYTE_ONE;
        mem_v = acc_v;
        z_we = 1'b1;
        z_src = acc_v;
      end
      `MIET_OP_FINC, `MIET_OP_FINC_ACC: begin
        acc_we = (op == `MIET_OP_FINC_ACC);
        mem_we = (op == `MIET_OP_FINC);
        acc_v = opd + `MIET_BYTE_ONE;
        mem_v = acc_v;
        z_we = 1'b1;
        z_src = acc_v;
      end
      `MIET_OP_FMOV_TO_ACC: begin
        acc_we = 1'b1;
        acc_v = opd;
      end
      `MIET_OP_FMOV_TO_MEM: begin
        mem_we = 1'b1;
        mem_v = acc_r;
      end
      `MIET_OP_FOR: begin
        acc_we = 1'b1;
        acc_v = acc_r | opd;
        z_we = 1'b1;
        z_src = acc_v;
      end
      default: bad = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  wire exec = (state_r == ST_EXEC);
  // a command written while busy is dropped: the core is single issue
  wire start = wr && (paddr == `MIET_OFS_CMD) && (state_r == ST_IDLE);

  always @* begin
    case (state_r)
      ST_IDLE: state_nxt = start ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = skip ? ST_DUMMY : ST_IDLE;
      ST_DUMMY: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state, command and status flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cmd_r <= `MIET_RST_WORD;
      busy_r <= 1'b0;
      skip_slot_r <= 1'b0;
      skipped_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != ST_IDLE);
      skip_slot_r <= (state_nxt == ST_DUMMY);
      if (start) begin
        cmd_r <= pwdata;
      end
      if (exec) begin
        skipped_r <= skip;
        bad_r <= bad;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural registers; an executing instruction wins over a bus write

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= `MIET_RST_BYTE;
      c_r <= 1'b0;
      hcarry_r <= 1'b0;
      z_r <= 1'b0;
      sexcess_r <= 1'b0;
      scarry_r <= 1'b0;
      tplo_r <= `MIET_RST_BYTE;
      tphi_r <= `MIET_RST_BYTE;
      thl_r <= `MIET_RST_BYTE;
      dptr_r <= {DM_AW{1'b0}};
      pptr_r <= {PM_AW{1'b0}};
    end else begin
      if (wr && paddr == `MIET_OFS_ACC) acc_r <= pwdata[7:0];
      if (wr && paddr == `MIET_OFS_FLAG) begin
        c_r <= pwdata[`MIET_FL_C];
        hcarry_r <= pwdata[`MIET_FL_HCARRY];
        z_r <= pwdata[`MIET_FL_Z];
        sexcess_r <= pwdata[`MIET_FL_SEXCESS];
        scarry_r <= pwdata[`MIET_FL_SCARRY];
      end
      if (wr && paddr == `MIET_OFS_TPLO) tplo_r <= pwdata[7:0];
      if (wr && paddr == `MIET_OFS_TPHI) tphi_r <= pwdata[7:0];
      if (wr && paddr == `MIET_OFS_DPTR) dptr_r <= pwdata[DM_AW-1:0];
      if (wr && paddr == `MIET_OFS_PPTR) pptr_r <= pwdata[PM_AW-1:0];
      if (exec) begin
        if (acc_we) acc_r <= acc_v;
        if (z_we) z_r <= (z_src == `MIET_BYTE_ZERO);
        if (ar_we) begin
          c_r <= sum9[8];
          hcarry_r <= sum5[4];
          sexcess_r <= add_excess;
          scarry_r <= add_excess ^ sum9[7];
        end
        if (c_we) c_r <= c_v;
        if (thl_we) thl_r <= pword[15:8];
        if (pre_inc) tplo_r <= tplo_use;
      end
    end
  end

  // memories have no reset; both ports may hit one cell, execute written last
  always @(posedge pclk) begin
    if (wr && paddr == `MIET_OFS_DDAT) dmem[dptr_r] <= pwdata[7:0];
    if (wr && paddr == `MIET_OFS_PDAT) pmem[pptr_r] <= pwdata[15:0];
    if (exec && mem_we) dmem[ea] <= mem_v;
  end

endmodule // miet_core

// *** miet_core_properties.sv ***
// concurrent checks on bus answers and instruction timing of the execute tail
`timescale 1ns/1ps
module miet_core_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire busy_r,
  input wire skip_slot_r
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // command accepted at its access edge; a busy core drops it
  wire cmd_go = psel && penable && pwrite && pready && paddr == 8'h00 && !busy_r;
  reg [4:0] op_r;
  // opcode of the last accepted command, needed to know who may skip
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= 5'h00;
    end else if (cmd_go) begin
      op_r <= pwdata[4:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_exec_plain;
    !busy_r;
  endsequence
  sequence s_exec_skip;
    busy_r && skip_slot_r ##1 !busy_r;
  endsequence
  property p_ready_setup;
    psel && !penable |=> pready;
  endproperty
  property p_ready_cause;
    pready |-> $past(psel) && !$past(penable);
  endproperty
  property p_err_bad;
    psel && !penable && (paddr > 8'h28 || paddr[1:0] != 2'h0) |=> pslverr;
  endproperty
  property p_err_good;
    psel && !penable && paddr <= 8'h28 && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  property p_rdata_idle;
    !(pready && !pwrite) |-> prdata == 32'h00000000;
  endproperty
  property p_busy_go;
    cmd_go && pwdata[4:0] <= 5'h1C |=> busy_r;
  endproperty
  property p_busy_len;
    $rose(busy_r) |-> !skip_slot_r ##1 (s_exec_plain or s_exec_skip);
  endproperty
  property p_skip_busy;
    skip_slot_r |-> busy_r && $past(busy_r);
  endproperty
  property p_skip_ops;
    $rose(busy_r) && !(op_r inside {5'h01, 5'h02, 5'h03}) |=> !skip_slot_r;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no ready after setup");
  a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
  a_err_bad: assert property (p_err_bad) else $error("unmapped access not refused");
  a_err_good: assert property (p_err_good) else $error("mapped access refused");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
  a_busy_go: assert property (p_busy_go) else $error("command did not start");
  a_busy_len: assert property (p_busy_len) else $error("bad execute length");
  a_skip_busy: assert property (p_skip_busy) else $error("dummy slot not in busy");
  a_skip_ops: assert property (p_skip_ops) else $error("skip from plain op");
endmodule // miet_core_props

bind miet_core miet_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy_r(busy_r), .skip_slot_r(skip_slot_r));

// *** miet_core_tb.sv ***
// self-checking bench of the execute tail: op table, table reads, bus corners
`timescale 1ns/1ps
`include "miet_regs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module miet_core_tb;
  reg pclk, presetn, psel, penable, pwrite, err;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, busy_r, skip_slot_r;
  integer errors = 0, check_count = 0, cyc = 0, i;
  reg [87:0] r;
  // op bitsec adr imm mem acc flg | exp acc mem flg stat
  reg [87:0] rows [0:30] = '{
    88'h000005003C001FC33C1F00, 88'h0100050000550055000002,
    88'h0100050001550055010000, 88'h0200050000770500000502,
    88'h0200050080000080800000, 88'h037005007F0000007F0002,
    88'h0330050008000000080000, 88'h080005005A5A1B005A1F00,
    88'h090005000FF004F0FF0000, 88'h0A00053C113C0000110400,
    88'h0B0140007F0001807F0A00, 88'h0C024000FF000100000700,
    88'h0D03400080800000801D00, 88'h0E01400012340134460000,
    88'h0F014000F00F0100F00500, 88'h10014000F33F043F330000,
    88'h11014000A5111F11001F00, 88'h12514000FF000000DF0000,
    88'h13014000FF220022000400, 88'h140140000F0004F00F0000,
    88'h15014000005B1E5B611E00, 88'h1501400000A304A3030500,
    88'h1501400000220322880300, 88'h1601400001330033000400,
    88'h17014000000004FF000000, 88'h18014000FF330033000400,
    88'h190140007F0004807F0000, 88'h1A01400000551B00001B00,
    88'h1B01400012A51BA5A51B00, 88'h1C01400000001B00001F00,
    88'h1D01400011220322110304};
  miet_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy_r(busy_r), .skip_slot_r(skip_slot_r));
  ////////////////////////////////////////////////////////////////
  // free-running core clock, 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // watchdog: a hung handshake counts as a mismatch
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
  end
  task end_of_test;
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one bus transfer; idle edge first so strobes are never re-driven in one step
  task apb(input reg wr, input reg [7:0] a, input reg [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // status, acc, flag, table pointer and latch registers come out of reset cleared
    for (i = 1; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h00000000);
      `CHK(rd, 32'h00000000)
    end
    apb(1'b0, 8'h2C, 32'h00000000);
    `CHK({err, rd}, 33'h100000000)
    apb(1'b1, 8'h06, 32'h000000FF);
    `CHK(err, 1'b1)
    // every opcode from the table, operands loaded through the bus
    for (i = 0; i < 31; i++) begin
      r = rows[i];
      apb(1'b1, `MIET_OFS_DPTR, {22'h000000, r[73:72], r[71:64]});
      apb(1'b1, `MIET_OFS_DDAT, {24'h000000, r[55:48]});
      apb(1'b1, `MIET_OFS_ACC, {24'h000000, r[47:40]});
      apb(1'b1, `MIET_OFS_FLAG, {24'h000000, r[39:32]});
      apb(1'b1, `MIET_OFS_CMD, {r[63:56], 6'h00, r[73:72], r[71:64], r[78:76], r[84:80]});
      repeat (3) @(posedge pclk);
      apb(1'b0, `MIET_OFS_ACC, 32'h00000000);
      `CHK(rd, {24'h000000, r[31:24]})
      apb(1'b0, `MIET_OFS_DDAT, 32'h00000000);
      `CHK(rd, {24'h000000, r[23:16]})
      apb(1'b0, `MIET_OFS_FLAG, 32'h00000000);
      `CHK(rd, {24'h000000, r[15:8]})
      apb(1'b0, `MIET_OFS_STAT, 32'h00000000);
      `CHK(rd & 32'h00000006, {24'h000000, r[7:0]})
    end
    // table reads: paged word at 123, final-page word at 323, with preincrement forms
    apb(1'b1, `MIET_OFS_PPTR, 32'h00000123);
    apb(1'b1, `MIET_OFS_PDAT, 32'h0000A55A);
    apb(1'b1, `MIET_OFS_PPTR, 32'h00000323);
    apb(1'b1, `MIET_OFS_PDAT, 32'h00003CC3);
    apb(1'b1, `MIET_OFS_TPHI, 32'h00000001);
    apb(1'b1, `MIET_OFS_DPTR, 32'h00000005);
    for (i = 4; i < 8; i++) begin
      apb(1'b1, `MIET_OFS_TPLO, i[1] ? 32'h00000022 : 32'h00000023);
      apb(1'b1, `MIET_OFS_CMD, {24'h000005, 3'h0, i[4:0]});
      repeat (3) @(posedge pclk);
      apb(1'b0, `MIET_OFS_DDAT, 32'h00000000);
      `CHK(rd, i[0] ? 32'h000000C3 : 32'h0000005A)
      apb(1'b0, `MIET_OFS_THL, 32'h00000000);
      `CHK(rd, i[0] ? 32'h0000003C : 32'h000000A5)
      apb(1'b0, `MIET_OFS_TPLO, 32'h00000000);
      `CHK(rd, 32'h00000023)
    end
    // the high latch is read-only from the bus
    apb(1'b1, `MIET_OFS_THL, 32'h000000FF);
    apb(1'b0, `MIET_OFS_THL, 32'h00000000);
    `CHK(rd, 32'h0000003C)
    // normal forms ignore the section field; the section 1 copy must stay unseen
    apb(1'b1, `MIET_OFS_DPTR, 32'h00000105);
    apb(1'b1, `MIET_OFS_DDAT, 32'h00000012);
    apb(1'b1, `MIET_OFS_DPTR, 32'h00000005);
    apb(1'b1, `MIET_OFS_DDAT, 32'h00000034);
    apb(1'b1, `MIET_OFS_CMD, 32'h00010500);
    repeat (3) @(posedge pclk);
    apb(1'b0, `MIET_OFS_ACC, 32'h00000000);
    `CHK(rd, 32'h00000043)
    // busy lasts one cycle for a kept instruction, two with a taken skip's dummy slot
    apb(1'b1, `MIET_OFS_CMD, 32'h00000501);
    @(negedge pclk);
    `CHK({busy_r, skip_slot_r}, 2'b10)
    @(negedge pclk);
    `CHK({busy_r, skip_slot_r}, 2'b00)
    apb(1'b1, `MIET_OFS_CMD, 32'h00000503);
    @(negedge pclk);
    `CHK({busy_r, skip_slot_r}, 2'b10)
    @(negedge pclk);
    `CHK({busy_r, skip_slot_r}, 2'b11)
    @(negedge pclk);
    `CHK({busy_r, skip_slot_r}, 2'b00)
    // a second reset in mid-run clears what the run left set
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 1; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h00000000);
      `CHK(rd, 32'h00000000)
    end
    end_of_test;
  end
endmodule // miet_core_tb
